// file: rtl/clk_ctrl_pkg.sv
package clk_ctrl_pkg;
   // register offsets on the plain register port
   localparam logic [3:0] OFS_CONTROL = 4'h0;
   localparam logic [3:0] OFS_TRIM = 4'h1;
   localparam logic [3:0] OFS_UNLOCK = 4'h2;
   localparam logic [3:0] OFS_POWER = 4'h3;
   // unlock key pair written to the unlock register
   localparam logic [15:0] UNLOCK_KEY_A = 16'h0055;
   localparam logic [15:0] UNLOCK_KEY_B = 16'h00AA;
   // unlock byte select carried in bit 8 of the second key write
   localparam int UNLOCK_HIGH_BIT = 8;
   // control register field positions
   localparam int CUR_SRC_LSB = 12;
   localparam int NEXT_SRC_LSB = 8;
   localparam int PLL_LOCK_BIT = 5;
   localparam int FAIL_FLAG_BIT = 3;
   localparam int SEC_EN_BIT = 1;
   localparam int SWITCH_REQ_BIT = 0;
   // trim field width and reset value
   localparam int TRIM_W = 6;
   localparam logic [5:0] TRIM_RESET = 6'h00;
   // power register codes
   localparam logic [1:0] PWR_SLEEP = 2'h1;
   localparam logic [1:0] PWR_IDLE = 2'h2;
   // settle count on the new clock
   localparam int SETTLE_CYCLES = 10;
   localparam logic [3:0] SETTLE_LAST = 4'(SETTLE_CYCLES - 1);
   // source encodings
   typedef enum logic [2:0] {
      SRC_FRC = 3'h0, SRC_FRC_PLL = 3'h1, SRC_PRI = 3'h2, SRC_PRI_PLL = 3'h3,
      SRC_SEC = 3'h4, SRC_LOW_POWER_RC_OSC = 3'h5, SRC_FRC_DIV16 = 3'h6, SRC_FRC_DIVN = 3'h7
   } source_e;
   // switch sequencer states, one-hot
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01, ST_CHECK = 5'h02, ST_WAIT_RDY = 5'h04, ST_SETTLE = 5'h08, ST_DONE = 5'h10
   } switch_state_e;
   // oscillator enables, one bit per oscillator plus one for the pll
   typedef struct packed {
      logic fast_rc_osc;
      logic primary;
      logic secondary;
      logic low_power_rc_osc;
      logic pll;
   } osc_en_s;
endpackage : clk_ctrl_pkg

// file: rtl/clock_switch_failsafe_sleep.sv
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
// Behaviour
// - trim code is signed around nominal centre
// - one trim step is about 0.375 percent
// - switching and monitor need config bit zero
// - disabled: next ignored, current shows initial
// - disabled: switch request held at zero
// - equal current and next aborts the switch
// - valid switch clears lock and fail flags
// - start source, wait startup or pll lock
// - count ten new clock cycles, then switch
// - done: clear request, copy next to current
// - stop old source except kept oscillators
// - processor keeps running during the switch
// - primary submode fixed by configuration
// - monitor keeps low power rc running awake
// - failure raises trap, falls back to fast rc
// - failure under pll falls back with pll
// - sleep stops clock, oscillators and monitor
// - watchdog cleared before sleep, rc kept
// - wake on interrupt, reset, watchdog timeout
// - idle halts processor, peripherals keep clock
// - three-bit source encoding shared by fields
// - fail flag set by monitor, software clears
// - control writes need an unlock first
module clock_switch_failsafe_sleep
   import clk_ctrl_pkg::*;
(
   // clock, reset, enable
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_clk_en,
   // register port
   input wire logic [3:0] i_reg_addr,
   input wire logic [15:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [15:0] o_reg_rdata,
   // configuration bits
   input wire logic i_switch_monitor_cfg,
   input wire logic [2:0] i_initial_source_cfg,
   input wire logic [1:0] i_primary_submode_cfg,
   input wire logic i_watchdog_en_cfg,
   // oscillator status from the analog side, asynchronous
   input wire logic i_osc_startup_done,
   input wire logic i_pll_locked,
   input wire logic i_new_clk_tick,
   input wire logic i_osc_fail,
   // wake events, asynchronous
   input wire logic i_wake_irq,
   input wire logic i_watchdog_timeout,
   // oscillator and clock controls
   output wire osc_en_s o_osc_en,
   output logic [2:0] o_sys_clk_sel,
   output logic [1:0] o_primary_submode,
   output logic [5:0] o_fast_rc_trim_code,
   output logic o_clock_fail_trap,
   output logic o_watchdog_clear,
   output logic o_cpu_halt,
   output logic o_periph_clk_en,
   output logic o_monitor_active
);
   // synchronisers for asynchronous inputs
   logic [5:0] sync1_r;
   logic [5:0] sync2_r;
   logic [5:0] async_in;
   assign async_in = {i_watchdog_timeout, i_wake_irq, i_osc_fail, i_new_clk_tick, i_pll_locked, i_osc_startup_done};
   wire ost_done_s = sync2_r[0];
   wire pll_lock_s = sync2_r[1];
   wire tick_s = sync2_r[2];
   wire fail_s = sync2_r[3];
   wire irq_s = sync2_r[4];
   wire wdt_to_s = sync2_r[5];
   // tick edge detect follows the second stage only
   logic tick_d_r;
   wire tick_rise = tick_s & ~tick_d_r;

   // register state
   logic [2:0] cur_src_r;
   logic [2:0] next_src_r;
   logic switch_req_r;
   logic pll_lock_r;
   logic fail_flag_r;
   logic sec_en_r;
   logic [5:0] trim_r;
   logic cfg_caught_r;
   logic key_a_r;
   logic permit_hi_r;
   logic permit_lo_r;
   logic sleep_r;
   logic idle_r;
   logic wdt_clear_r;
   logic trap_r;
   logic [3:0] settle_r;
   switch_state_e state_r;
   switch_state_e state_nxt;

   // decode helpers
   function automatic logic uses_pll(input logic [2:0] src);
      uses_pll = (src == SRC_FRC_PLL) || (src == SRC_PRI_PLL);
   endfunction : uses_pll
   function automatic logic is_crystal(input logic [2:0] src);
      is_crystal = (src == SRC_PRI) || (src == SRC_PRI_PLL) || (src == SRC_SEC);
   endfunction : is_crystal

   wire switch_allowed = ~i_switch_monitor_cfg;
   wire monitor_on = ~i_switch_monitor_cfg;
   // register strobes
   wire wr_ctrl = i_reg_wr && (i_reg_addr == OFS_CONTROL);
   wire wr_trim = i_reg_wr && (i_reg_addr == OFS_TRIM);
   wire wr_unlock = i_reg_wr && (i_reg_addr == OFS_UNLOCK);
   wire wr_power = i_reg_wr && (i_reg_addr == OFS_POWER);
   // control writes land only with a permit
   wire hi_write = wr_ctrl && permit_hi_r;
   wire lo_write = wr_ctrl && permit_lo_r;
   wire req_write = lo_write && i_reg_wdata[SWITCH_REQ_BIT] && switch_allowed;
   wire redundant = (next_src_r == cur_src_r);
   wire src_ready = (~is_crystal(next_src_r) || ost_done_s) && (~uses_pll(next_src_r) || pll_lock_s);
   // failure only when monitor runs, awake, after the initial source load
   wire fail_event = fail_s && monitor_on && ~sleep_r && cfg_caught_r;
   wire wake = irq_s || wdt_to_s;

   // switch sequencer next state
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE: if (switch_req_r && ~sleep_r) state_nxt = ST_CHECK;
         ST_CHECK: state_nxt = redundant ? ST_IDLE : ST_WAIT_RDY;
         ST_WAIT_RDY: if (src_ready) state_nxt = ST_SETTLE;
         ST_SETTLE: if (tick_rise && settle_r == SETTLE_LAST) state_nxt = ST_DONE;
         ST_DONE: state_nxt = ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
      // failure aborts any switch in progress
      if (fail_event)
         state_nxt = ST_IDLE;
   end

   // synchronisers and edge history
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         sync1_r <= 6'h00;
         sync2_r <= 6'h00;
         tick_d_r <= 1'b0;
      end
      else if (i_clk_en)
      begin
         sync1_r <= async_in;
         sync2_r <= sync1_r;
         tick_d_r <= tick_s;
      end
   end

   // unlock permits
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         key_a_r <= 1'b0;
         permit_hi_r <= 1'b0;
         permit_lo_r <= 1'b0;
      end
      else if (i_clk_en)
      begin
         if (wr_unlock)
            key_a_r <= (i_reg_wdata == UNLOCK_KEY_A);
         // key pair grants one byte permit
         if (wr_unlock && key_a_r && i_reg_wdata[7:0] == UNLOCK_KEY_B[7:0])
         begin
            permit_hi_r <= i_reg_wdata[UNLOCK_HIGH_BIT];
            permit_lo_r <= ~i_reg_wdata[UNLOCK_HIGH_BIT];
         end
         // any control write consumes the permit
         else if (wr_ctrl)
         begin
            permit_hi_r <= 1'b0;
            permit_lo_r <= 1'b0;
         end
      end
   end

   // control register, sequencer and failsafe
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         cfg_caught_r <= 1'b0;
         cur_src_r <= SRC_FRC;
         next_src_r <= SRC_FRC;
         switch_req_r <= 1'b0;
         pll_lock_r <= 1'b0;
         fail_flag_r <= 1'b0;
         sec_en_r <= 1'b0;
         trap_r <= 1'b0;
         settle_r <= 4'h0;
         state_r <= ST_IDLE;
      end
      else if (i_clk_en)
      begin
         state_r <= state_nxt;
         trap_r <= 1'b0;
         // first cycle after reset: load the initial source
         if (~cfg_caught_r)
         begin
            cfg_caught_r <= 1'b1;
            cur_src_r <= i_initial_source_cfg;
            next_src_r <= i_initial_source_cfg;
         end
         // next field writable only with switching on
         if (hi_write && switch_allowed)
            next_src_r <= i_reg_wdata[NEXT_SRC_LSB +: 3];
         if (lo_write)
            sec_en_r <= i_reg_wdata[SEC_EN_BIT];
         if (req_write)
            switch_req_r <= 1'b1;
         if (lo_write && ~i_reg_wdata[FAIL_FLAG_BIT])
            fail_flag_r <= 1'b0;
         if (state_r == ST_CHECK && redundant)
            switch_req_r <= 1'b0;
         // valid switch clears lock and fail
         if (state_r == ST_CHECK && ~redundant)
         begin
            pll_lock_r <= 1'b0;
            fail_flag_r <= 1'b0;
         end
         // lock status follows the pll while waiting on a pll source
         if (state_r == ST_WAIT_RDY && uses_pll(next_src_r))
            pll_lock_r <= pll_lock_s;
         if (state_r != ST_SETTLE)
            settle_r <= 4'h0;
         else if (tick_rise)
            settle_r <= settle_r + 4'h1;
         if (state_r == ST_DONE)
         begin
            switch_req_r <= 1'b0;
            cur_src_r <= next_src_r;
         end
         // failure traps and falls back, set wins over clear
         if (fail_event && cur_src_r != SRC_FRC && cur_src_r != SRC_FRC_PLL)
         begin
            trap_r <= 1'b1;
            fail_flag_r <= 1'b1;
            switch_req_r <= 1'b0;
            // keep the pll when it was in use
            cur_src_r <= uses_pll(cur_src_r) ? SRC_FRC_PLL : SRC_FRC;
            next_src_r <= uses_pll(cur_src_r) ? SRC_FRC_PLL : SRC_FRC;
         end
         // held at zero while switching is off
         if (~switch_allowed)
            switch_req_r <= 1'b0;
         if (~switch_allowed)
            cur_src_r <= i_initial_source_cfg;
      end
   end

   // trim and power modes
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         trim_r <= TRIM_RESET;
         sleep_r <= 1'b0;
         idle_r <= 1'b0;
         wdt_clear_r <= 1'b0;
      end
      else if (i_clk_en)
      begin
         wdt_clear_r <= 1'b0;
         if (wr_trim)
            trim_r <= i_reg_wdata[TRIM_W-1:0];
         // wake returns to run with same source
         if (wake)
         begin
            sleep_r <= 1'b0;
            idle_r <= 1'b0;
         end
         else if (wr_power && i_reg_wdata[1:0] == PWR_SLEEP)
         begin
            sleep_r <= 1'b1;
            wdt_clear_r <= i_watchdog_en_cfg;
         end
         else if (wr_power && i_reg_wdata[1:0] == PWR_IDLE)
         begin
            idle_r <= 1'b1;
            wdt_clear_r <= i_watchdog_en_cfg;
         end
      end
   end

   // register read data, one cycle after the strobe
   // both source fields share one code
   logic [15:0] ctrl_view;
   assign ctrl_view = {1'b0, cur_src_r, 1'b0, next_src_r, 2'h0, pll_lock_r, 1'b0,
                       fail_flag_r, 1'b0, sec_en_r, switch_req_r};
   logic [15:0] rd_mux;
   assign rd_mux = (i_reg_addr == OFS_CONTROL) ? ctrl_view :
                   (i_reg_addr == OFS_TRIM) ? {10'h000, trim_r} :
                   (i_reg_addr == OFS_POWER) ? {14'h0000, idle_r, sleep_r} : 16'h0000;
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         o_reg_rdata <= 16'h0000;
      else if (i_clk_en && i_reg_rd)
         o_reg_rdata <= rd_mux;
   end

   // oscillator enables
   wire switching = (state_r == ST_WAIT_RDY) || (state_r == ST_SETTLE) || (state_r == ST_DONE);
   wire [2:0] want_src = switching ? next_src_r : cur_src_r;
   function automatic logic src_is_frc(input logic [2:0] src);
      src_is_frc = (src == SRC_FRC) || (src == SRC_FRC_PLL) || (src == SRC_FRC_DIV16) || (src == SRC_FRC_DIVN);
   endfunction : src_is_frc
   // old and new both run during a switch, old stops after
   // sleep turns off the system source
   assign o_osc_en.fast_rc_osc = ~sleep_r && (src_is_frc(cur_src_r) || src_is_frc(want_src));
   assign o_osc_en.primary = ~sleep_r && (is_crystal(cur_src_r) && cur_src_r != SRC_SEC ||
                                          is_crystal(want_src) && want_src != SRC_SEC);
   // secondary kept while its enable stays set
   assign o_osc_en.secondary = sec_en_r || (~sleep_r && (cur_src_r == SRC_SEC || want_src == SRC_SEC));
   // low power rc kept for monitor or watchdog
   assign o_osc_en.low_power_rc_osc = i_watchdog_en_cfg || (monitor_on && ~sleep_r) ||
                          (~sleep_r && (cur_src_r == SRC_LOW_POWER_RC_OSC || want_src == SRC_LOW_POWER_RC_OSC));
   assign o_osc_en.pll = ~sleep_r && (uses_pll(cur_src_r) || uses_pll(want_src));
   // source changes at completion, failure fallback or initial-source load, cpu never stalled for it
   assign o_sys_clk_sel = cur_src_r;
   assign o_primary_submode = i_primary_submode_cfg;
   // each code step is one analog trim step
   assign o_fast_rc_trim_code = trim_r;
   assign o_clock_fail_trap = trap_r;
   assign o_watchdog_clear = wdt_clear_r;
   // idle halts the cpu, peripherals stay clocked
   assign o_cpu_halt = sleep_r || idle_r;
   assign o_periph_clk_en = ~sleep_r;
   assign o_monitor_active = monitor_on && ~sleep_r;

   // checks
   a_redundant_abort: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_clk_en && state_r == ST_CHECK && redundant && ~fail_event |=> ~switch_req_r && state_r == ST_IDLE)
      else $error("redundant switch not aborted");
   a_req_disabled: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_switch_monitor_cfg && $past(i_switch_monitor_cfg) |-> ~switch_req_r)
      else $error("switch request set while switching disabled");
   a_switch_clears: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_clk_en && state_r == ST_CHECK && ~redundant && ~fail_event |=> ~fail_flag_r)
      else $error("valid switch did not clear fail flag");
   a_done_handover: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_clk_en && state_r == ST_DONE && switch_allowed && ~fail_event |=> cur_src_r == $past(next_src_r) && ~switch_req_r)
      else $error("completion did not hand over source");
   a_settle_count: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      state_r == ST_DONE |-> $past(settle_r) == SETTLE_LAST)
      else $error("switch completed without ten ticks");
   a_fail_trap: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_clk_en && fail_event && ~uses_pll(cur_src_r) && (cur_src_r != SRC_FRC) && switch_allowed
      |=> o_clock_fail_trap && fail_flag_r && cur_src_r == SRC_FRC)
      else $error("failure did not trap to fast rc");
   a_fail_pll: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_clk_en && fail_event && (cur_src_r == SRC_PRI_PLL) && switch_allowed |=> cur_src_r == SRC_FRC_PLL)
      else $error("pll failure did not keep pll");
   a_sleep_monitor: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      sleep_r |-> ~o_monitor_active && ~o_periph_clk_en && o_cpu_halt)
      else $error("sleep left monitor or peripherals on");
   a_trim_upper: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      $past(i_clk_en && i_reg_rd && i_reg_addr == OFS_TRIM) |-> o_reg_rdata[15:6] == 10'h000)
      else $error("trim upper bits not zero");
endmodule : clock_switch_failsafe_sleep

// file: testbench/testbench.sv
`timescale 1ns/1ps
module testbench
   import clk_ctrl_pkg::*;
;
   // clock, reset and register port drive
   logic i_clk, i_sys_rst;
   logic [3:0] i_reg_addr;
   logic [15:0] i_reg_wdata;
   logic i_reg_wr, i_reg_rd;
   logic [15:0] o_reg_rdata;
   // configuration and analog status drive
   logic sw_cfg, wd_cfg, osc_up, pll_lk, tick, osc_fail, wake_irq, wd_tmo;
   logic [2:0] init_src;
   logic [1:0] sub_cfg;
   // design outputs
   osc_en_s osc_en;
   logic [2:0] sys_sel;
   logic [1:0] sub_out;
   logic [5:0] trim_out;
   logic trap, wd_clr, halt, periph_en, mon_act;
   // bookkeeping
   int bad_count, samples_checked, cycle_count;
   logic [15:0] v;

   clock_switch_failsafe_sleep i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_clk_en(1'b1),
      .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
      .o_reg_rdata(o_reg_rdata), .i_switch_monitor_cfg(sw_cfg), .i_initial_source_cfg(init_src),
      .i_primary_submode_cfg(sub_cfg), .i_watchdog_en_cfg(wd_cfg), .i_osc_startup_done(osc_up),
      .i_pll_locked(pll_lk), .i_new_clk_tick(tick), .i_osc_fail(osc_fail), .i_wake_irq(wake_irq),
      .i_watchdog_timeout(wd_tmo), .o_osc_en(osc_en), .o_sys_clk_sel(sys_sel), .o_primary_submode(sub_out),
      .o_fast_rc_trim_code(trim_out), .o_clock_fail_trap(trap), .o_watchdog_clear(wd_clr),
      .o_cpu_halt(halt), .o_periph_clk_en(periph_en), .o_monitor_active(mon_act));

   // 200 MHz clock
   initial
   begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end

   // compare seen against expected, count both outcomes
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // verdict and end of run
   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : summarize

   // one-cycle write strobe
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_reg_wr <= 1'b1;
      i_reg_addr <= a;
      i_reg_wdata <= d;
      @(posedge i_clk);
      i_reg_wr <= 1'b0;
   endtask : wr

   // one-cycle read strobe, data taken in the following cycle
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge i_clk);
      i_reg_rd <= 1'b1;
      i_reg_addr <= a;
      @(posedge i_clk);
      i_reg_rd <= 1'b0;
      // data stood through the cycle after the strobe, taken at its closing edge
      @(posedge i_clk);
      d = o_reg_rdata;
   endtask : rd

   // key pair, bit 8 picks the byte to be opened
   task automatic unlock(input logic high);
      wr(OFS_UNLOCK, UNLOCK_KEY_A);
      wr(OFS_UNLOCK, high ? (UNLOCK_KEY_B | 16'h0100) : UNLOCK_KEY_B);
   endtask : unlock

   // full software switch request
   task automatic req_switch(input logic [2:0] src);
      unlock(1'b1);
      wr(OFS_CONTROL, {5'h00, src, 8'h00});
      unlock(1'b0);
      wr(OFS_CONTROL, 16'h0001);
      repeat (8) @(posedge i_clk);
   endtask : req_switch

   // new-clock cycles as rising edges, slow enough for the synchroniser
   task automatic ticks(input int n);
      repeat (n)
      begin
         tick <= 1'b1;
         repeat (2) @(posedge i_clk);
         tick <= 1'b0;
         repeat (2) @(posedge i_clk);
      end
      repeat (6) @(posedge i_clk);
   endtask : ticks

   // current source and request bit of the control register
   task automatic ctl(input logic [2:0] cur, input logic req);
      rd(OFS_CONTROL, v);
      chk(16'(v[14:12]), 16'(cur));
      chk(16'(v[0]), 16'(req));
   endtask : ctl

   // bounded wait for a one-cycle pulse, sel 0 trap, 1 watchdog clear
   task automatic pulse(input logic sel);
      logic seen;
      seen = 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         #1 seen = seen | (sel ? wd_clr : trap);
         @(posedge i_clk);
      end
      chk(16'(seen), 16'h0001);
   endtask : pulse

   task automatic do_reset();
      i_sys_rst <= 1'b1;
      repeat (4) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      repeat (2) @(posedge i_clk);
   endtask : do_reset

   // hang guard
   always @(posedge i_clk)
   begin
      cycle_count++;
      if (cycle_count == 20000)
      begin
         bad_count++;
         $display("[ERR] %0t run did not finish", $time);
         summarize();
      end
   end

   // main sequence
   initial
   begin
      bad_count = 0;
      samples_checked = 0;
      cycle_count = 0;
      i_sys_rst = 1'b1;
      i_reg_addr = 4'h0;
      i_reg_wdata = 16'h0000;
      i_reg_wr = 1'b0;
      i_reg_rd = 1'b0;
      sw_cfg = 1'b0;
      wd_cfg = 1'b1;
      osc_up = 1'b1;
      pll_lk = 1'b0;
      tick = 1'b0;
      osc_fail = 1'b0;
      wake_irq = 1'b0;
      wd_tmo = 1'b0;
      init_src = SRC_FRC;
      sub_cfg = 2'h2;
      do_reset();
      // reset values, trim field and unmapped index
      rd(OFS_TRIM, v);
      chk(v, 16'h0000);
      ctl(SRC_FRC, 1'b0);
      wr(OFS_TRIM, 16'hFFFF);
      rd(OFS_TRIM, v);
      chk(v, 16'h003F);
      chk(16'(trim_out), 16'h003F);
      wr(OFS_TRIM, 16'h0020);
      rd(OFS_TRIM, v);
      chk(v, 16'h0020);
      rd(4'h9, v);
      chk(v, 16'h0000);
      chk(16'(sub_out), 16'h0002);
      $display("test registers done");
      // switch to low power rc: nine new cycles are not enough
      req_switch(SRC_LOW_POWER_RC_OSC);
      ticks(9);
      ctl(SRC_FRC, 1'b1);
      chk(16'(halt), 16'h0000);
      ticks(1);
      ctl(SRC_LOW_POWER_RC_OSC, 1'b0);
      chk(16'(sys_sel), 16'(SRC_LOW_POWER_RC_OSC));
      chk(16'(osc_en.low_power_rc_osc), 16'h0001);
      // same source again aborts without a change
      req_switch(SRC_LOW_POWER_RC_OSC);
      ctl(SRC_LOW_POWER_RC_OSC, 1'b0);
      // control write without unlock is dropped
      wr(OFS_CONTROL, {5'h00, SRC_PRI, 8'h00});
      rd(OFS_CONTROL, v);
      chk(16'(v[10:8]), 16'(SRC_LOW_POWER_RC_OSC));
      $display("test switch done");
      // oscillator failure falls back to fast rc
      osc_fail <= 1'b1;
      pulse(1'b0);
      osc_fail <= 1'b0;
      rd(OFS_CONTROL, v);
      chk(16'(v[3]), 16'h0001);
      chk(16'(v[14:12]), 16'(SRC_FRC));
      // unlocked low byte write clears the flag, the next write needs a new unlock
      unlock(1'b0);
      wr(OFS_CONTROL, 16'h0000);
      wr(OFS_CONTROL, 16'h0002);
      rd(OFS_CONTROL, v);
      chk(16'(v[3]), 16'h0000);
      chk(16'(v[1]), 16'h0000);
      $display("test failure done");
      // pll source waits for lock before counting
      // pll mode entered here from plain fast rc, the current source
      req_switch(SRC_PRI_PLL);
      ticks(12);
      ctl(SRC_FRC, 1'b1);
      chk(16'(v[5]), 16'h0000);
      pll_lk <= 1'b1;
      repeat (6) @(posedge i_clk);
      ticks(10);
      ctl(SRC_PRI_PLL, 1'b0);
      chk(16'(v[5]), 16'h0001);
      chk(16'(osc_en.primary), 16'h0001);
      chk(16'(osc_en.fast_rc_osc), 16'h0000);
      chk(16'(osc_en.pll), 16'h0001);
      // failure under pll keeps the pll
      osc_fail <= 1'b1;
      pulse(1'b0);
      osc_fail <= 1'b0;
      ctl(SRC_FRC_PLL, 1'b0);
      $display("test pll done");
      // sleep, then wake on interrupt
      wr(OFS_POWER, {14'h0000, PWR_SLEEP});
      pulse(1'b1);
      chk(16'(halt), 16'h0001);
      chk(16'(periph_en), 16'h0000);
      chk(16'(mon_act), 16'h0000);
      chk(16'(osc_en.low_power_rc_osc), 16'h0001);
      wake_irq <= 1'b1;
      repeat (4) @(posedge i_clk);
      wake_irq <= 1'b0;
      repeat (4) @(posedge i_clk);
      chk(16'(halt), 16'h0000);
      chk(16'(sys_sel), 16'(SRC_FRC_PLL));
      // idle, then wake on watchdog timeout
      wr(OFS_POWER, {14'h0000, PWR_IDLE});
      repeat (2) @(posedge i_clk);
      chk(16'(halt), 16'h0001);
      chk(16'(periph_en), 16'h0001);
      rd(OFS_POWER, v);
      chk(v, 16'h0002);
      wd_tmo <= 1'b1;
      repeat (4) @(posedge i_clk);
      wd_tmo <= 1'b0;
      repeat (4) @(posedge i_clk);
      chk(16'(halt), 16'h0000);
      $display("test power done");
      // switching disabled by configuration
      sw_cfg <= 1'b1;
      init_src <= SRC_SEC;
      do_reset();
      ctl(SRC_SEC, 1'b0);
      req_switch(SRC_LOW_POWER_RC_OSC);
      ctl(SRC_SEC, 1'b0);
      chk(16'(sys_sel), 16'(SRC_SEC));
      chk(16'(osc_en.secondary), 16'h0001);
      init_src <= SRC_PRI;
      repeat (4) @(posedge i_clk);
      ctl(SRC_PRI, 1'b0);
      $display("test disabled done");
      summarize();
   end
endmodule : testbench
